//--- hw/asr_routing_map.vh
`ifndef ASR_ROUTING_MAP_VH
`define ASR_ROUTING_MAP_VH

// Register offsets (byte addresses)
`define ASR_OFS_CTRL      12'h000
`define ASR_OFS_STATUS    12'h004
`define ASR_OFS_FRAMES    12'h008

// Control fields
`define ASR_CTRL_ENABLE   0
`define ASR_CTRL_FLUSH    1

// Status fields
`define ASR_ST_ACTIVE     0
`define ASR_ST_FILL_LO    1
`define ASR_ST_FILL_HI    2
`define ASR_ST_ITYPE      3
`define ASR_ST_CHAIN      4
`define ASR_ST_SPLIT      5
`define ASR_ST_SECOND     6

// Reset values
`define ASR_CTRL_RESET    1'h1
`define ASR_FRAMES_RESET  16'h0000

// Interface type select levels
`define ASR_ITYPE_PAR     1'h0
`define ASR_ITYPE_SER     1'h1

// Synchroniser depth and channel layout
`define ASR_SYNC_STAGES   2
`define ASR_CH_COUNT      8
`define ASR_CH_WIDTH      16

`endif

//--- hw/asr_serial_routing.v
// Function
// [RQ1] Select pin chooses parallel (0) or serial (1)
// [RQ2] Parallel bus driven only while select low
// [RQ3] Frame sync falling edge starts serial frame
// [RQ4] Chain fourth input feeds lane D when split
// [RQ5] Chain third input feeds lane C when split
// [RQ6] Chain second input feeds lane B when enabled
// [RQ7] Chain first input always feeds lane A
// [RQ8] Board grounds chain inputs when chain disabled
// [RQ9] Split high: pair C on C, D on D
// [RQ10] Split low, B on: A+C on A, B+D on B
// [RQ11] Split low, B off: all on lane A
// [RQ12] Chain enable turns low bus bits into inputs
// [RQ13] Second select low: lane B off, A only
// [RQ14] Board grounds lane C when split low
// [RQ15] Own results first, then chain bits follow
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`include "asr_routing_map.vh"
`timescale 1ns/100ps
`default_nettype none

module asr_serial_routing #(
   parameter FRAME_W = 128
)(
   // Clock and reset
   input  wire               clk,
   input  wire               rst_n,
   // APB slave
   input  wire               psel,
   input  wire               penable,
   input  wire               pwrite,
   input  wire [11:0]        paddr,
   input  wire [31:0]        pwdata,
   output reg  [31:0]        prdata,
   output wire               pready,
   output wire               pslverr,
   // Conversion results, eight channels, channel A0 in the top bits
   input  wire               resValid,
   input  wire [FRAME_W-1:0] resData,
   output wire               resReady,
   // Mode pins
   input  wire               interfaceTypeSelect,
   input  wire               chainInputEnable,
   input  wire               pairSplitSelect,
   input  wire               secondOutputSelect,
   // Serial link pins
   input  wire               serialClk,
   input  wire               frameSyncStrobe_n,
   output wire               serialLaneA,
   output wire               serialLaneB,
   output wire               serialLaneC,
   output wire               serialLaneD,
   // Shared parallel bus; low bits double as chain inputs
   input  wire [15:0]        dbIn,
   output reg  [15:0]        dbOut,
   output reg                dbOe_n
);

   localparam CW    = `ASR_CH_WIDTH;
   localparam NSYNC = 9;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   reg  [NSYNC-1:0] syncA_ff;
   reg  [NSYNC-1:0] syncB_ff;
   reg              sclkPrev_ff;
   reg              fsPrev_ff;

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         syncA_ff    <= 9'h100;
         syncB_ff    <= 9'h100;
         sclkPrev_ff <= 1'b0;
         fsPrev_ff   <= 1'b1;
      end
      else
      begin
         syncA_ff    <= {frameSyncStrobe_n, serialClk, interfaceTypeSelect, chainInputEnable,
                         pairSplitSelect, secondOutputSelect, 3'h0};
         syncB_ff    <= syncA_ff;
         sclkPrev_ff <= syncB_ff[7];
         fsPrev_ff   <= syncB_ff[8];
      end
   end

   reg  [3:0] chainA_ff;
   reg  [3:0] chainB_ff;

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         chainA_ff <= 4'h0;
         chainB_ff <= 4'h0;
      end
      else
      begin
         chainA_ff <= dbIn[3:0];
         chainB_ff <= chainA_ff;
      end
   end

   wire fsSync     = syncB_ff[8];
   wire sclkSync   = syncB_ff[7];
   wire isSerial   = (syncB_ff[6] == `ASR_ITYPE_SER);                        // [RQ1]
   wire chainEn    = syncB_ff[5] & isSerial;                                 // [RQ12]
   wire splitSel   = syncB_ff[4];
   wire secondSel  = syncB_ff[3];
   wire sclkFall   = sclkPrev_ff & ~sclkSync;
   wire fsFall     = fsPrev_ff & ~fsSync;
   wire fsRise     = ~fsPrev_ff & fsSync;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Two-entry result buffer

   reg  [FRAME_W-1:0] bufMem_ff [0:1];
   reg                wrPtr_ff;
   reg                rdPtr_ff;
   reg  [1:0]         fill_ff;
   reg                ctrlEnable_ff;
   reg                flushReq_ff;
   wire               pop;

   assign resReady = (fill_ff != 2'h2) & ~flushReq_ff;
   wire   push     = resValid & resReady;
   wire   headValid = (fill_ff != 2'h0);
   wire [FRAME_W-1:0] head = bufMem_ff[rdPtr_ff];

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         wrPtr_ff <= 1'b0;
         rdPtr_ff <= 1'b0;
         fill_ff  <= 2'h0;
      end
      else if (flushReq_ff)
      begin
         wrPtr_ff <= 1'b0;
         rdPtr_ff <= 1'b0;
         fill_ff  <= 2'h0;
      end
      else
      begin
         if (push)
            wrPtr_ff <= ~wrPtr_ff;
         if (pop)
            rdPtr_ff <= ~rdPtr_ff;
         if (push & ~pop)
            fill_ff <= fill_ff + 2'h1;
         else if (pop & ~push)
            fill_ff <= fill_ff - 2'h1;
      end
   end

   always @(posedge clk)
   begin
      if (push)
         bufMem_ff[wrPtr_ff] <= resData;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Lane routing at frame start

   wire [CW-1:0] ch0 = head[FRAME_W-1 -: CW];
   wire [CW-1:0] ch1 = head[FRAME_W-1-CW -: CW];
   wire [CW-1:0] ch2 = head[FRAME_W-1-2*CW -: CW];
   wire [CW-1:0] ch3 = head[FRAME_W-1-3*CW -: CW];
   wire [CW-1:0] ch4 = head[FRAME_W-1-4*CW -: CW];
   wire [CW-1:0] ch5 = head[FRAME_W-1-5*CW -: CW];
   wire [CW-1:0] ch6 = head[FRAME_W-1-6*CW -: CW];
   wire [CW-1:0] ch7 = head[FRAME_W-1-7*CW -: CW];

   reg [FRAME_W-1:0] loadA;
   reg [FRAME_W-1:0] loadB;
   reg [FRAME_W-1:0] loadC;
   reg [FRAME_W-1:0] loadD;

   always @*
   begin
      loadA = {FRAME_W{1'b0}};
      loadB = {FRAME_W{1'b0}};
      loadC = {FRAME_W{1'b0}};
      loadD = {FRAME_W{1'b0}};
      if (headValid)
      begin
         if (splitSel)
         begin
            loadC = {ch4, ch5, {(FRAME_W-2*CW){1'b0}}};                     // [RQ9]
            loadD = {ch6, ch7, {(FRAME_W-2*CW){1'b0}}};                     // [RQ9]
            if (secondSel)
            begin
               loadA = {ch0, ch1, {(FRAME_W-2*CW){1'b0}}};
               loadB = {ch2, ch3, {(FRAME_W-2*CW){1'b0}}};
            end
            else
               loadA = {ch0, ch1, ch2, ch3, {(FRAME_W-4*CW){1'b0}}};        // [RQ13]
         end
         else if (secondSel)
         begin
            loadA = {ch0, ch1, ch4, ch5, {(FRAME_W-4*CW){1'b0}}};           // [RQ10]
            loadB = {ch2, ch3, ch6, ch7, {(FRAME_W-4*CW){1'b0}}};           // [RQ10]
         end
         else
            loadA = head;                                                   // [RQ11] [RQ13]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Serial frame engine

   reg  [FRAME_W-1:0] shiftA_ff;
   reg  [FRAME_W-1:0] shiftB_ff;
   reg  [FRAME_W-1:0] shiftC_ff;
   reg  [FRAME_W-1:0] shiftD_ff;
   reg                frameActive_ff;
   reg  [15:0]        frames_ff;

   wire serRun    = isSerial & ctrlEnable_ff;
   wire frameGo   = serRun & fsFall & ~frameActive_ff;                      // [RQ3]
   wire serPop    = frameGo & headValid;

   wire chainBitA = chainEn & chainB_ff[3];                                  // [RQ7]
   wire chainBitB = chainEn & secondSel & chainB_ff[2];                      // [RQ6]
   wire chainBitC = chainEn & splitSel & chainB_ff[1];                       // [RQ5]
   wire chainBitD = chainEn & splitSel & chainB_ff[0];                       // [RQ4]

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         shiftA_ff      <= {FRAME_W{1'b0}};
         shiftB_ff      <= {FRAME_W{1'b0}};
         shiftC_ff      <= {FRAME_W{1'b0}};
         shiftD_ff      <= {FRAME_W{1'b0}};
         frameActive_ff <= 1'b0;
      end
      else if (frameGo)
      begin
         shiftA_ff      <= loadA;
         shiftB_ff      <= loadB;
         shiftC_ff      <= loadC;
         shiftD_ff      <= loadD;
         frameActive_ff <= 1'b1;
      end
      else if (frameActive_ff & (fsRise | ~isSerial))
      begin
         shiftA_ff      <= {FRAME_W{1'b0}};
         shiftB_ff      <= {FRAME_W{1'b0}};
         shiftC_ff      <= {FRAME_W{1'b0}};
         shiftD_ff      <= {FRAME_W{1'b0}};
         frameActive_ff <= 1'b0;
      end
      else if (frameActive_ff & sclkFall)
      begin
         shiftA_ff <= {shiftA_ff[FRAME_W-2:0], chainBitA};                   // [RQ15]
         shiftB_ff <= {shiftB_ff[FRAME_W-2:0], chainBitB};                   // [RQ15]
         shiftC_ff <= {shiftC_ff[FRAME_W-2:0], chainBitC};                   // [RQ15]
         shiftD_ff <= {shiftD_ff[FRAME_W-2:0], chainBitD};                   // [RQ15]
      end
   end

   assign serialLaneA = shiftA_ff[FRAME_W-1];
   assign serialLaneB = shiftB_ff[FRAME_W-1];
   assign serialLaneC = shiftC_ff[FRAME_W-1];
   assign serialLaneD = shiftD_ff[FRAME_W-1];

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Parallel read-out: one word per chip-select pulse

   reg  [2:0] parIdx_ff;
   wire       csLow    = ~fsSync;
   wire       parMode  = ~isSerial & ctrlEnable_ff;
   wire       parStep  = parMode & fsRise & headValid;
   wire       parPop   = parStep & (parIdx_ff == 3'h7);

   assign pop = serPop | parPop;

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         parIdx_ff <= 3'h0;
         dbOut     <= 16'h0000;
         dbOe_n    <= 1'b1;
      end
      else
      begin
         if (parStep)
            parIdx_ff <= parIdx_ff + 3'h1;
         else if (flushReq_ff)
            parIdx_ff <= 3'h0;
         dbOut  <= headValid ? head[FRAME_W-1-CW*parIdx_ff -: CW] : 16'h0000;
         dbOe_n <= ~(parMode & csLow & headValid);                           // [RQ2]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // APB register file

   wire apbSetup  = psel & ~penable;
   wire apbAccess = psel & penable;
   wire mapped    = (paddr == `ASR_OFS_CTRL) | (paddr == `ASR_OFS_STATUS) | (paddr == `ASR_OFS_FRAMES);
   wire wrCtrl    = apbAccess & pwrite & (paddr == `ASR_OFS_CTRL);
   wire wrFrames  = apbAccess & pwrite & (paddr == `ASR_OFS_FRAMES);

   assign pready  = 1'b1;
   assign pslverr = apbAccess & ~mapped;

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         ctrlEnable_ff <= `ASR_CTRL_RESET;
         flushReq_ff   <= 1'b0;
         frames_ff     <= `ASR_FRAMES_RESET;
         prdata        <= 32'h00000000;
      end
      else
      begin
         if (wrCtrl)
            ctrlEnable_ff <= pwdata[`ASR_CTRL_ENABLE];
         flushReq_ff <= wrCtrl & pwdata[`ASR_CTRL_FLUSH];
         if (frameGo)
            frames_ff <= wrFrames ? 16'h0001 : frames_ff + 16'h0001;
         else if (wrFrames)
            frames_ff <= `ASR_FRAMES_RESET;
         if (apbSetup)
         begin
            prdata <= 32'h00000000;
            case (paddr)
               `ASR_OFS_CTRL:
                  prdata[`ASR_CTRL_ENABLE] <= ctrlEnable_ff;
               `ASR_OFS_STATUS:
               begin
                  prdata[`ASR_ST_ACTIVE]                     <= frameActive_ff;
                  prdata[`ASR_ST_FILL_HI:`ASR_ST_FILL_LO]    <= fill_ff;
                  prdata[`ASR_ST_ITYPE]                      <= isSerial;
                  prdata[`ASR_ST_CHAIN]                      <= chainEn;
                  prdata[`ASR_ST_SPLIT]                      <= splitSel;
                  prdata[`ASR_ST_SECOND]                     <= secondSel;
               end
               `ASR_OFS_FRAMES:
                  prdata[15:0] <= frames_ff;
               default:
                  prdata <= 32'h00000000;
            endcase
         end
      end
   end

endmodule // asr_serial_routing

`default_nettype wire

//--- tb/asr_routing_props.sv
`timescale 1ns/100ps
`default_nettype none
module asr_routing_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Mode and frame pins
   input wire logic interfaceTypeSelect,
   input wire logic pairSplitSelect,
   input wire logic secondOutputSelect,
   input wire logic frameSyncStrobe_n,
   // Watched outputs
   input wire logic serialLaneA,
   input wire logic serialLaneB,
   input wire logic serialLaneC,
   input wire logic serialLaneD,
   input wire logic dbOe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   serial_bus_off_a: assert property (interfaceTypeSelect [*5] |-> dbOe_n) else $error("bus in serial");
   bus_needs_cs_a: assert property ($fell(dbOe_n) |-> !frameSyncStrobe_n && !interfaceTypeSelect)
      else $error("bus without cs");
   bus_release_a: assert property ($rose(frameSyncStrobe_n) |-> ##[1:6] dbOe_n) else $error("bus held");
   bus_hold_a: assert property (!dbOe_n && !frameSyncStrobe_n |=> !dbOe_n) else $error("bus dropped");
   lanes_idle_a: assert property (frameSyncStrobe_n [*6] |-> !(serialLaneA | serialLaneB | serialLaneC | serialLaneD))
      else $error("lanes busy outside frame");
   lane_b_off_a: assert property (!secondOutputSelect [*4] |-> !serialLaneB) else $error("lane b active");
   lanes_cd_off_a: assert property (!pairSplitSelect [*4] |-> !serialLaneC && !serialLaneD)
      else $error("lane c or d active");
   single_lane_a: assert property ((!pairSplitSelect && !secondOutputSelect) [*4] |-> !(serialLaneB | serialLaneC))
      else $error("extra lane active");
endmodule // asr_routing_props

bind asr_serial_routing asr_routing_props asr_routing_props_inst (.clk, .rst_n, .interfaceTypeSelect,
   .pairSplitSelect, .secondOutputSelect, .frameSyncStrobe_n, .serialLaneA, .serialLaneB, .serialLaneC,
   .serialLaneD, .dbOe_n);
`default_nettype wire

//--- tb/asr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module asr_host_model (
   // Clock
   input  wire logic        clk,
   // Link
   input  wire logic [3:0]  lanes,
   output var  logic        serialClk,
   output var  logic        frameSyncStrobe_n,
   // Parallel bus
   input  wire logic [15:0] dbOut,
   input  wire logic        dbOe_n
);
   logic [135:0] got [4];
   initial
   begin
      serialClk = 1'b0;
      frameSyncStrobe_n = 1'b1;
   end
   // Half of the 160 ns link period
   task automatic half();
      repeat (10) @(posedge clk);
   endtask
   // Link clock stands low outside frames
   task automatic read_frame(input int n);
      frameSyncStrobe_n <= 1'b0;
      for (int i = 0; i < n; i++)
      begin
         half();
         serialClk <= 1'b1;
         for (int l = 0; l < 4; l++)
            got[l] = {got[l][134:0], lanes[l]};
         half();
         serialClk <= 1'b0;
      end
      half();
      frameSyncStrobe_n <= 1'b1;
      half();
   endtask
   task automatic read_word(output logic [15:0] w, output logic oe);
      frameSyncStrobe_n <= 1'b0;
      half();
      w = dbOut;
      oe = dbOe_n;
      frameSyncStrobe_n <= 1'b1;
      half();
   endtask
endmodule // asr_host_model
`default_nettype wire

//--- tb/testbench.sv
`include "asr_routing_map.vh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic         clk = 1'b0;
   logic         rst_n = 1'b0;
   logic         psel = 1'b0;
   logic         penable = 1'b0;
   logic         pwrite = 1'b0;
   logic [11:0]  paddr = 12'h000;
   logic [31:0]  pwdata = 32'h0;
   logic         resValid = 1'b0;
   logic [127:0] resData = 128'h0;
   logic         interfaceTypeSelect = 1'b1;
   logic         chainInputEnable = 1'b1;
   logic         pairSplitSelect = 1'b0;
   logic         secondOutputSelect = 1'b0;
   logic [15:0]  dbIn = 16'h000F;
   wire  [31:0]  prdata;
   wire  [15:0]  dbOut;
   wire          pready, pslverr, resReady, serialClk, frameSyncStrobe_n, dbOe_n;
   wire          serialLaneA, serialLaneB, serialLaneC, serialLaneD;
   int           nErrors = 0;
   int           checksDone = 0;
   always #4 clk = ~clk;
   asr_serial_routing asr_serial_routing_inst (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .resValid, .resData, .resReady, .interfaceTypeSelect, .chainInputEnable,
      .pairSplitSelect, .secondOutputSelect, .serialClk, .frameSyncStrobe_n, .serialLaneA, .serialLaneB,
      .serialLaneC, .serialLaneD, .dbIn, .dbOut, .dbOe_n);
   asr_host_model asr_host_model_inst (.clk, .serialClk, .frameSyncStrobe_n, .dbOut, .dbOe_n,
      .lanes({serialLaneD, serialLaneC, serialLaneB, serialLaneA}));
   task automatic chk(input string what, input logic [135:0] exp, input logic [135:0] got);
      checksDone++;
      if (got !== exp)
      begin
         nErrors++;
         $display("[ERR] %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic push(input logic [127:0] w);
      @(posedge clk);
      resValid <= 1'b1;
      resData <= w;
      do @(posedge clk); while (resReady !== 1'b1);
      resValid <= 1'b0;
   endtask
   function automatic logic [127:0] word(input int k);
      word = 128'h1111_2222_3333_4444_5555_6666_7777_8888 ^ {128{k[0]}};
   endfunction
   // Own part of a lane for split s and second b
   function automatic logic [127:0] own(input logic [127:0] w, input int l, input logic s, input logic b);
      case (l)
         0: own = s ? (b ? {w[127:96], 96'h0} : {w[127:64], 64'h0}) : (b ? {w[127:96], w[63:32], 64'h0} : w);
         1: own = !b ? 128'h0 : (s ? {w[95:64], 96'h0} : {w[95:64], w[31:0], 64'h0});
         default: own = !s ? 128'h0 : {(l == 2 ? w[63:32] : w[31:0]), 96'h0};
      endcase
   endfunction
   task automatic stopTest();
      if (nErrors == 0 && checksDone > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      #400000;
      nErrors++;
      stopTest();
   end
   initial
   begin
      logic [31:0] q;
      logic        e;
      logic [15:0] w;
      logic        oe;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, `ASR_OFS_CTRL, 32'h00000000, q, e);
      chk("ctrl", `ASR_CTRL_RESET, q);
      apb(1'b1, 12'h00C, 32'h00000000, q, e);
      chk("unmapped", 1'b1, e);
      push(word(0));
      push(word(1));
      @(posedge clk);
      chk("full", 1'b0, resReady);
      for (int i = 0; i < 4; i++)
      begin
         pairSplitSelect <= i[1];
         secondOutputSelect <= i[0];
         if (i > 1)
            push(word(i));
         repeat (5) @(posedge clk);
         asr_host_model_inst.read_frame(136);
         for (int l = 0; l < 4; l++)
            chk("lane", {own(word(i), l, i[1], i[0]), {8{l == 0 || (l == 1 && i[0]) || (l > 1 && i[1])}}},
               asr_host_model_inst.got[l]);
      end
      apb(1'b0, `ASR_OFS_FRAMES, 32'h00000000, q, e);
      chk("frames", 16'h0004, q);
      apb(1'b0, `ASR_OFS_STATUS, 32'h00000000, q, e);
      chk("status", 32'h00000078, q);
      apb(1'b1, `ASR_OFS_FRAMES, 32'h00000000, q, e);
      apb(1'b1, `ASR_OFS_CTRL, 32'h00000000, q, e);
      push(word(1));
      repeat (5) @(posedge clk);
      asr_host_model_inst.read_frame(8);
      chk("idle lane", 8'h00, asr_host_model_inst.got[0][7:0]);
      apb(1'b0, `ASR_OFS_FRAMES, 32'h00000000, q, e);
      chk("frames clr", 16'h0000, q);
      apb(1'b0, `ASR_OFS_STATUS, 32'h00000000, q, e);
      chk("held", 32'h0000007A, q);
      apb(1'b1, `ASR_OFS_CTRL, 32'h00000003, q, e);
      apb(1'b0, `ASR_OFS_STATUS, 32'h00000000, q, e);
      chk("flushed", 32'h00000078, q);
      interfaceTypeSelect <= 1'b0;
      chainInputEnable <= 1'b0;
      dbIn <= 16'h0000;
      push(word(1));
      repeat (5) @(posedge clk);
      for (int k = 0; k < 9; k++)
      begin
         asr_host_model_inst.read_word(w, oe);
         chk("bus oe", k == 8, oe);
         if (k < 8)
            chk("bus word", word(1) >> (112 - 16 * k) & 128'hFFFF, w);
      end
      chk("bus idle", 1'b1, dbOe_n);
      stopTest();
   end
endmodule // testbench
`default_nettype wire
